/* File: sck_host_model.sv */
// Host-side serial clock source feeding the lock block's read latency.
// Assumes run is high only while the block works on a command.
module sck_host_model (
  // Frame control
  input  wire logic run,
  // Serial clock
  output logic      sck
);
  timeunit 1ns;
  timeprecision 1ns;

  // Stands low between frames; odd start keeps phase unrelated to clk
  initial begin
    sck = 1'b0;
    #137;
    forever begin
      #400;
      sck = run ? ~sck : 1'b0;
    end
  end
endmodule

/* File: sector_lock.sv */
// Per-sector program/erase lock logic: persistent and volatile lock bits,
// guard bit, and a classic Wishbone slave through which commands arrive.
// Assumes the mode select comes from same-clock OTP logic and the serial
// clock sck arrives asynchronously from the pin.
//
// The register offsets and register access over Wishbone were chosen for this implementation.

module sector_lock #(
  parameter int SECTORS        = 256,
  parameter int PROG_CYCLES    = sector_lock_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES   = sector_lock_pkg::ERASE_CYCLES,
  parameter int READ_LAT_EDGES = sector_lock_pkg::READ_LAT_EDGES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial link clock and mode strap
  input  wire logic        sck,
  input  wire logic        password_mode,
  // Device status
  output logic             busy_o
);

  localparam int SW = $clog2(SECTORS);
  localparam int CW = 16;

  typedef enum logic [5:0] {
    ST_INIT  = 6'b000001,
    ST_IDLE  = 6'b000010,
    ST_PROG  = 6'b000100,
    ST_PRE   = 6'b001000,
    ST_ERASE = 6'b010000,
    ST_RDLAT = 6'b100000
  } state_e;

  // Sector lookup used by several checks
  function automatic logic bit_at(input logic [SECTORS-1:0] v, input logic [SW-1:0] i);
    bit_at = v[i];
  endfunction

  // Register state
  state_e              state_r, state_nxt;
  logic [CW-1:0]       cnt_r, cnt_nxt;
  logic [SECTORS-1:0]  plock_r = {SECTORS{sector_lock_pkg::FACTORY_PLK}};
  logic [SECTORS-1:0]  vlock_r;
  logic                guard_r;
  logic                fail_r;
  logic                rd_valid_r;
  logic                rd_value_r;
  logic                array_ok_r;
  logic [SW-1:0]       sect_r;
  logic [7:0]          bp_first_r;
  logic [7:0]          bp_last_r;
  logic                bp_en_r;
  logic                sck_s1_r, sck_s2_r, sck_s3_r;

  // Bus decode
  wire       req      = wb_cyc_i & wb_stb_i;
  wire       wr_take  = req & wb_we_i & wb_ack_o;
  wire       hit_cmd  = wb_adr_i == sector_lock_pkg::CMD_OFS;
  wire       hit_st   = wb_adr_i == sector_lock_pkg::STATUS_OFS;
  wire       hit_bp   = wb_adr_i == sector_lock_pkg::BPROT_OFS;
  wire       hit_lk   = wb_adr_i == sector_lock_pkg::LOCKS_OFS;
  wire       lane0    = wb_sel_i[0];
  wire       lane1    = wb_sel_i[1];
  wire       lane2    = wb_sel_i[2];
  wire       cmd_wr   = wr_take & hit_cmd & lane0;
  wire [3:0] op       = wb_dat_i[sector_lock_pkg::OP_LSB +: sector_lock_pkg::OP_W];
  wire [SW-1:0] sect  = wb_dat_i[sector_lock_pkg::SECT_LSB +: SW];
  wire       arg      = wb_dat_i[sector_lock_pkg::ARG_BIT];
  wire       idle     = state_r == ST_IDLE;

  // Command classification; all but volatile writes, guard clears and soft resets need idle, else they are refused
  wire is_prog   = cmd_wr & (op == sector_lock_pkg::OP_PLOCK_PROG);
  wire is_erase  = cmd_wr & (op == sector_lock_pkg::OP_PLOCK_ERASE);
  wire is_read   = cmd_wr & (op == sector_lock_pkg::OP_PLOCK_READ);
  wire is_vwr    = cmd_wr & (op == sector_lock_pkg::OP_VLOCK_WRITE);
  wire is_gclr   = cmd_wr & (op == sector_lock_pkg::OP_GUARD_CLEAR);
  wire is_unlock = cmd_wr & (op == sector_lock_pkg::OP_PASS_UNLOCK);
  wire is_check  = cmd_wr & (op == sector_lock_pkg::OP_ARRAY_CHECK);
  wire is_sreset = cmd_wr & (op == sector_lock_pkg::OP_SOFT_RESET);

  // Persistent changes need idle and guard at one
  wire plk_ok     = idle & guard_r;
  wire prog_go    = is_prog & plk_ok;
  wire erase_go   = is_erase & plk_ok;
  wire read_go    = is_read & idle;
  // The password compare is outside; arg carries its match result
  wire unlock_ok  = is_unlock & idle & password_mode & arg;
  // Persistent mode never re-arms the guard by command
  wire unlock_bad = is_unlock & ~unlock_ok;

  // Effective protection of the addressed sector
  // Range hit uses the same 8-bit sector index as the command field
  wire [7:0] sect8    = 8'(sect);
  wire bp_hit     = bp_en_r & (sect8 >= bp_first_r) & (sect8 <= bp_last_r);
  wire lock_hit   = ~bit_at(plock_r, sect) | ~bit_at(vlock_r, sect);
  wire protected_ = bp_hit | lock_hit;
  wire check_go   = is_check & idle;

  // Refused attempts raise the sticky failure flag
  // Guard or busy refusal leaves every persistent bit as it was, except a check refused in ST_PROG, which retargets the program via sect_r
  wire refuse_plk  = (is_prog | is_erase) & ~plk_ok;
  // A read or check while busy would race the running operation
  wire refuse_busy = (is_read | is_check) & ~idle;
  // A protected sector fails its check even when idle
  wire refuse_prot = is_check & protected_;
  wire refuse      = refuse_plk | refuse_busy | refuse_prot | unlock_bad;
  wire fail_clr = wr_take & hit_st & lane0 & wb_dat_i[sector_lock_pkg::ST_FAIL];

  // Link clock edge detect after the two-flop synchroniser
  wire sck_rise = sck_s2_r & ~sck_s3_r;

  // Timer terminal counts
  // Counter is sized for the default erase count; larger counts need a wider CW
  wire [CW-1:0] prog_last  = CW'(PROG_CYCLES - 1);
  wire [CW-1:0] erase_last = CW'(ERASE_CYCLES - 1);
  wire [CW-1:0] lat_last   = CW'(READ_LAT_EDGES - 1);
  wire          cnt_done_p = cnt_r == prog_last;
  wire          cnt_done_e = cnt_r == erase_last;
  wire          cnt_done_l = cnt_r == lat_last;

  // Read data selection; unmapped addresses read as zero
  wire [31:0] status_word = {25'h0, array_ok_r, password_mode, rd_value_r, rd_valid_r,
                             guard_r, fail_r, ~idle};
  wire [31:0] bp_word     = {15'h0, bp_en_r, bp_last_r, bp_first_r};
  wire [31:0] lk_word     = {30'h0, bit_at(vlock_r, sect_r), bit_at(plock_r, sect_r)};
  wire [31:0] rd_word     = hit_st ? status_word :
                            hit_bp ? bp_word :
                            hit_lk ? lk_word : 32'h0000_0000;
  // Read data is loaded only for the answer cycle; outside it the bus sees
  // zero, so a request still held at the ack edge leaves no stale word
  wire        rd_load     = req & ~wb_we_i & ~wb_ack_o;

  // Operation sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_INIT: begin
        // One cycle lets the mode strap settle the guard
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        // Volatile writes, guard clears and checks need no sequencer time
        cnt_nxt = '0;
        if (prog_go) begin
          state_nxt = ST_PROG;
        end else if (erase_go) begin
          state_nxt = ST_PRE;
        end else if (read_go) begin
          state_nxt = ST_RDLAT;
        end
      end
      ST_PROG: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_done_p) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PRE: begin
        // Internal preprogram and verify pass before the group erase
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_done_p) begin
          state_nxt = ST_ERASE;
          cnt_nxt   = '0;
        end
      end
      ST_ERASE: begin
        // All bits return to one together when the count runs out
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_done_e) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RDLAT: begin
        // Latency counted in link clock edges, as an array read is
        if (sck_rise) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_done_l) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Captured sector for program and read
  // A check captures its sector even when refused, for the lock view
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sect_r <= '0;
    end else if (prog_go | read_go | is_check) begin
      sect_r <= sect;
    end
  end

  // Persistent bits: no reset, they model nonvolatile cells
  // A refused program or erase never reaches these branches, since the
  // sequencer only enters ST_PROG or ST_PRE through prog_go or erase_go
  always_ff @(posedge clk) begin
    if (state_r == ST_PROG && cnt_done_p) begin
      plock_r[sect_r] <= 1'b0;
    end else if (state_r == ST_PRE && cnt_done_p) begin
      plock_r <= '0;
    end else if (state_r == ST_ERASE && cnt_done_e) begin
      plock_r <= {SECTORS{1'b1}};
    end
  end

  // Volatile bits: writable regardless of guard; lost on any reset
  // Soft reset restores them too, so no volatile protection outlives it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vlock_r <= {SECTORS{sector_lock_pkg::RST_VLOCK}};
    end else if (is_sreset) begin
      vlock_r <= {SECTORS{sector_lock_pkg::RST_VLOCK}};
    end else if (is_vwr) begin
      vlock_r[sect] <= arg;
    end
  end

  // Guard: reset value fixed, then mode decides in the init cycle
  // The reset branch stays constant; the mode strap is read one cycle
  // later, and no guard command takes effect before idle, so that cycle is harmless
  // Software reset is not decoded here: the guard keeps its value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_r <= sector_lock_pkg::RST_GUARD;
    end else if (state_r == ST_INIT) begin
      guard_r <= ~password_mode;
    end else if (is_gclr) begin
      guard_r <= 1'b0;
    end else if (unlock_ok) begin
      guard_r <= 1'b1;
    end
  end

  // Sticky failure flag; a new failure beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fail_r <= 1'b0;
    end else if (refuse) begin
      fail_r <= 1'b1;
    end else if (fail_clr) begin
      fail_r <= 1'b0;
    end
  end

  // Persistent bit read result
  // Cleared at the start so software never takes a stale answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
      rd_value_r <= 1'b0;
    end else if (read_go) begin
      rd_valid_r <= 1'b0;
    end else if (state_r == ST_RDLAT && sck_rise && cnt_done_l) begin
      rd_valid_r <= 1'b1;
      rd_value_r <= bit_at(plock_r, sect_r);
    end
  end

  // Main-array permission check result
  // A busy check keeps the old answer; the fail flag reports the refusal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      array_ok_r <= 1'b0;
    end else if (check_go) begin
      array_ok_r <= ~protected_;
    end
  end

  // Block-protect range, held for the range checker
  // Each byte lane updates its own field, so software may patch one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bp_first_r <= 8'h00;
      bp_last_r  <= 8'h00;
      bp_en_r    <= 1'b0;
    end else if (wr_take & hit_bp) begin
      if (lane0) begin
        bp_first_r <= wb_dat_i[sector_lock_pkg::BP_FIRST_LSB +: 8];
      end
      if (lane1) begin
        bp_last_r <= wb_dat_i[sector_lock_pkg::BP_LAST_LSB +: 8];
      end
      if (lane2) begin
        bp_en_r <= wb_dat_i[sector_lock_pkg::BP_EN_BIT];
      end
    end
  end

  // Link clock synchroniser; only the second and third stages feed logic
  // The third stage only remembers the last level for edge detection
  // A stray edge outside a read is ignored by the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
    end else begin
      sck_s1_r <= sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
    end
  end

  // Wishbone answer: one wait cycle, ack dropped the cycle after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_load ? rd_word : 32'h0000_0000;
    end
  end

  // Busy mirror for the serial status path
  // Follows the next state so busy drops in step with the idle return
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_o <= 1'b1;
    end else begin
      busy_o <= state_nxt != ST_IDLE;
    end
  end

endmodule

/* File: sector_lock_pkg.sv */
// Constants for the per-sector program/erase lock block.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
package sector_lock_pkg;

  // Register byte offsets
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] BPROT_OFS  = 8'h08;
  localparam logic [7:0] LOCKS_OFS  = 8'h0C;

  // Command register fields
  localparam int OP_LSB     = 0;
  localparam int OP_W       = 4;
  localparam int SECT_LSB   = 8;
  localparam int ARG_BIT    = 16;

  // Command codes
  localparam logic [3:0] OP_NONE        = 4'h0;
  localparam logic [3:0] OP_PLOCK_PROG  = 4'h1;
  localparam logic [3:0] OP_PLOCK_ERASE = 4'h2;
  localparam logic [3:0] OP_PLOCK_READ  = 4'h3;
  localparam logic [3:0] OP_VLOCK_WRITE = 4'h4;
  localparam logic [3:0] OP_GUARD_CLEAR = 4'h5;
  localparam logic [3:0] OP_PASS_UNLOCK = 4'h6;
  localparam logic [3:0] OP_ARRAY_CHECK = 4'h7;
  localparam logic [3:0] OP_SOFT_RESET  = 4'h8;

  // Status register bit positions
  localparam int ST_BUSY     = 0;
  localparam int ST_FAIL     = 1;
  localparam int ST_GUARD    = 2;
  localparam int ST_RD_VALID = 3;
  localparam int ST_RD_VALUE = 4;
  localparam int ST_PW_MODE  = 5;
  localparam int ST_ARRAY_OK = 6;

  // Block-protect range register fields
  localparam int BP_FIRST_LSB = 0;
  localparam int BP_LAST_LSB  = 8;
  localparam int BP_EN_BIT    = 16;

  // Reset values
  localparam logic RST_GUARD   = 1'b1;
  localparam logic RST_VLOCK   = 1'b1;
  localparam logic FACTORY_PLK = 1'b1;

  // Timing: clock rate and nominal operation times
  localparam int CLK_HZ           = 10_000_000;
  localparam int PROG_TIME_US     = 300;
  localparam int ERASE_TIME_US    = 1000;
  localparam int PROG_CYCLES      = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_CYCLES     = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int READ_LAT_EDGES   = 8;

endpackage

/* File: sector_lock_props.sv */
// Concurrent checks on the lock block's bus answer and busy flag.
// Sees only the top module's ports; attached by the bind below.
module sector_lock_props #(
  parameter int PROG_CYCLES    = 4,
  parameter int ERASE_CYCLES   = 6,
  parameter int READ_LAT_EDGES = 2
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Mode and status
  input wire logic        password_mode,
  input wire logic        busy_o
);
  // Longest busy spell: erase plus read latency with slack for sck phase
  localparam int MAXB = 2 * (PROG_CYCLES + ERASE_CYCLES) + 40 * READ_LAT_EDGES + 16;

  // Decoded bus events
  wire req    = wb_cyc_i & wb_stb_i;
  wire rd_ack = wb_ack_o & ~wb_we_i;
  wire mapped = (wb_adr_i[7:4] == 4'h0) & (wb_adr_i[1:0] == 2'h0);
  wire is_st  = wb_adr_i == sector_lock_pkg::STATUS_OFS;
  wire rd_cmd = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == sector_lock_pkg::CMD_OFS)
              & (wb_dat_i[3:0] == sector_lock_pkg::OP_PLOCK_READ);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_ack_one_wait: assert property ($rose(req) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_has_req: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_mode_status: assert property (rd_ack && is_st |-> wb_dat_o[sector_lock_pkg::ST_PW_MODE] == password_mode)
    else $error("mode bit wrong in status");
  chk_read_busy: assert property (rd_cmd && wb_ack_o && !busy_o |-> ##[1:2] busy_o)
    else $error("lock read did not raise busy");
  chk_busy_ends: assert property ($rose(busy_o) |-> ##[1:MAXB] !busy_o)
    else $error("busy never ended");
  chk_init_done: assert property ($past(rst) |=> !busy_o)
    else $error("busy after init");
endmodule

bind sector_lock sector_lock_props #(
  .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES),
  .READ_LAT_EDGES(READ_LAT_EDGES)
) u_props (
  .clk           (clk),
  .rst           (rst),
  .wb_cyc_i      (wb_cyc_i),
  .wb_stb_i      (wb_stb_i),
  .wb_we_i       (wb_we_i),
  .wb_adr_i      (wb_adr_i),
  .wb_sel_i      (wb_sel_i),
  .wb_dat_i      (wb_dat_i),
  .wb_dat_o      (wb_dat_o),
  .wb_ack_o      (wb_ack_o),
  .password_mode (password_mode),
  .busy_o        (busy_o)
);

/* File: test_sector_lock.sv */
// Self-checking bench for the lock block over classic Wishbone.
// Assumes the host clock model runs sck while the block is busy.
module test_sector_lock;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ERASE_C = 6;

  // Bench signals
  logic        clk, rst, cyc, stb, we, pw_mode;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdata;
  wire  [31:0] dat_o;
  wire         ack, busy, sck;
  int          err_count, cmp_count, cycles, n_p, n_e;

  sector_lock #(.SECTORS(256), .PROG_CYCLES(4), .ERASE_CYCLES(ERASE_C), .READ_LAT_EDGES(2)) uut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sck(sck),
    .password_mode(pw_mode), .busy_o(busy));

  sck_host_model u_host (.run(busy), .sck(sck));

  // Clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdata = dat_o;
    check({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [7:0] s, input logic a);
    xfer(1'b1, sector_lock_pkg::CMD_OFS, {15'h0, a, s, 4'h0, op});
  endtask

  task automatic stbit(input int b, input logic e);
    xfer(1'b0, sector_lock_pkg::STATUS_OFS, 32'h0);
    check({31'h0, rdata[b]}, {31'h0, e});
  endtask

  // Busy wait bounded; first two cycles let busy rise
  task automatic idle(output int n);
    n = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic hreset(input logic m);
    pw_mode <= m;
    rst     <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Test sequence; fail flag cleared by writing its bit
  initial begin
    clk = 1'b0;
    {cyc, stb, we, pw_mode, adr, sel, dat} = '0;
    {err_count, cmp_count, cycles} = '0;
    hreset(1'b0);
    stbit(sector_lock_pkg::ST_GUARD, 1'b1);
    xfer(1'b0, 8'h10, 32'h0);
    check(rdata, 32'h0);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h03, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b1);
    cmd(sector_lock_pkg::OP_VLOCK_WRITE, 8'h03, 1'b0);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h03, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b0);
    stbit(sector_lock_pkg::ST_FAIL, 1'b1);
    cmd(sector_lock_pkg::OP_VLOCK_WRITE, 8'h03, 1'b1);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h03, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b1);
    xfer(1'b1, sector_lock_pkg::BPROT_OFS, 32'h0001_0C0A);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h0B, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b0);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h0D, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b1);
    xfer(1'b1, sector_lock_pkg::BPROT_OFS, 32'h0);
    $display("volatile and range tests done");
    cmd(sector_lock_pkg::OP_PLOCK_PROG, 8'h05, 1'b0);
    idle(n_p);
    cmd(sector_lock_pkg::OP_PLOCK_READ, 8'h05, 1'b0);
    idle(n_e);
    stbit(sector_lock_pkg::ST_RD_VALID, 1'b1);
    stbit(sector_lock_pkg::ST_RD_VALUE, 1'b0);
    xfer(1'b0, sector_lock_pkg::LOCKS_OFS, 32'h0);
    check({30'h0, rdata[1:0]}, 32'h2);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h05, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b0);
    cmd(sector_lock_pkg::OP_PLOCK_ERASE, 8'h00, 1'b0);
    idle(n_e);
    check({31'h0, n_e >= ERASE_C && n_p < ERASE_C}, 32'h1);
    cmd(sector_lock_pkg::OP_PLOCK_READ, 8'h05, 1'b0);
    idle(n_e);
    stbit(sector_lock_pkg::ST_RD_VALUE, 1'b1);
    $display("persistent bit tests done");
    cmd(sector_lock_pkg::OP_PLOCK_PROG, 8'h07, 1'b0);
    stbit(sector_lock_pkg::ST_BUSY, 1'b1);
    idle(n_p);
    xfer(1'b1, sector_lock_pkg::STATUS_OFS, 32'h2);
    cmd(sector_lock_pkg::OP_GUARD_CLEAR, 8'h00, 1'b0);
    stbit(sector_lock_pkg::ST_GUARD, 1'b0);
    cmd(sector_lock_pkg::OP_PLOCK_PROG, 8'h06, 1'b0);
    stbit(sector_lock_pkg::ST_FAIL, 1'b1);
    cmd(sector_lock_pkg::OP_PLOCK_ERASE, 8'h00, 1'b0);
    stbit(sector_lock_pkg::ST_BUSY, 1'b0);
    cmd(sector_lock_pkg::OP_PLOCK_READ, 8'h07, 1'b0);
    idle(n_e);
    stbit(sector_lock_pkg::ST_RD_VALUE, 1'b0);
    cmd(sector_lock_pkg::OP_PASS_UNLOCK, 8'h00, 1'b1);
    stbit(sector_lock_pkg::ST_GUARD, 1'b0);
    cmd(sector_lock_pkg::OP_VLOCK_WRITE, 8'h09, 1'b0);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h09, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b0);
    cmd(sector_lock_pkg::OP_SOFT_RESET, 8'h00, 1'b0);
    stbit(sector_lock_pkg::ST_GUARD, 1'b0);
    cmd(sector_lock_pkg::OP_ARRAY_CHECK, 8'h09, 1'b0);
    stbit(sector_lock_pkg::ST_ARRAY_OK, 1'b1);
    $display("guard tests done");
    hreset(1'b1);
    stbit(sector_lock_pkg::ST_GUARD, 1'b0);
    cmd(sector_lock_pkg::OP_PLOCK_READ, 8'h07, 1'b0);
    idle(n_e);
    stbit(sector_lock_pkg::ST_RD_VALUE, 1'b0);
    cmd(sector_lock_pkg::OP_PASS_UNLOCK, 8'h00, 1'b0);
    stbit(sector_lock_pkg::ST_GUARD, 1'b0);
    cmd(sector_lock_pkg::OP_PASS_UNLOCK, 8'h00, 1'b1);
    stbit(sector_lock_pkg::ST_GUARD, 1'b1);
    $display("password mode tests done");
    tally_and_finish();
  end
endmodule
